// ---- rtl/view_seq.sv ----
// View scroll sequencer with per-line value store and master polling
`timescale 1ns/10ps
`include "view_consts.svh"
module view_seq #(
  parameter int SEC_CYC  = `SEC_CYCLES,
  parameter int POLL_TMO = `POLL_TIMEOUT_CYC
) (
  input  wire logic         CLOCK_IN,
  input  wire logic         RST_B_IN,
  // Operator keys, from pins
  input  wire logic         KEY_UP_IN,
  input  wire logic         KEY_DOWN_IN,
  // Device settings
  input  wire logic         AUTO_SCROLL_IN,
  input  wire logic [5:0]   DWELL_SEC_IN,
  input  wire logic [6:0]   BRIGHT_PCT_IN,
  input  wire logic         MODE_SLAVE_IN,
  input  wire logic [7:0]   OWN_ADDR_IN,
  // View configuration write port
  input  wire logic         VCFG_WE_IN,
  input  wire logic [3:0]   VCFG_VIEW_IN,
  input  wire logic         VCFG_SHOW_IN,
  input  wire logic [2:0]   VCFG_ROWS_IN,
  input  wire logic [23:0]  VCFG_IDX_IN,
  // Display line configuration write port
  input  wire logic         LCFG_WE_IN,
  input  wire logic [5:0]   LCFG_LINE_IN,
  input  wire logic [7:0]   LCFG_SLAVE_IN,
  input  wire logic [15:0]  LCFG_REG_IN,
  input  wire view_pkg::dtype_t LCFG_TYPE_IN,
  input  wire logic [2:0]   LCFG_DEC_IN,
  // Value write from the Modbus slave engine
  input  wire logic         SVAL_WE_IN,
  input  wire logic [15:0]  SVAL_REG_IN,
  input  wire logic [31:0]  SVAL_DATA_IN,
  // Master poll request to the Modbus frame engine
  output logic              POLL_REQ_OUT,
  output logic [7:0]        POLL_FUNC_OUT,
  output logic [7:0]        POLL_SLAVE_OUT,
  output logic [15:0]       POLL_REG_OUT,
  output logic [1:0]        POLL_COUNT_OUT,
  input  wire logic         POLL_ACK_IN,
  input  wire logic         POLL_DONE_IN,
  input  wire logic         POLL_OK_IN,
  input  wire logic [31:0]  POLL_DATA_IN,
  // Slave engine address, zero while master
  output logic [7:0]        SLAVE_ADDR_OUT,
  // Presentation
  output logic [3:0]        VIEW_OUT,
  output logic [2:0]        ROWS_OUT,
  output logic [1:0]        FONT_SIZE_OUT,
  output logic [7:0]        ROW_HEIGHT_OUT,
  input  wire logic [1:0]   RD_ROW_IN,
  output logic [31:0]       RD_VALUE_OUT,
  output logic [7:0]        RD_SLAVE_OUT,
  output logic [15:0]       RD_REG_OUT,
  output logic [2:0]        RD_TYPE_OUT,
  output logic [2:0]        RD_DEC_OUT,
  output logic              BACKLIGHT_OUT
);
  import view_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Configuration and value storage
  logic        show_ff  [10];
  logic [2:0]  rows_ff  [10];
  logic [5:0]  idx_ff   [10][4];
  logic [7:0]  lslv_ff  [40];
  logic [15:0] lreg_ff  [40];
  dtype_t      ltyp_ff  [40];
  logic [2:0]  ldec_ff  [40];
  logic [31:0] lval_ff  [40];

  function automatic logic [2:0] clamp_rows(input logic [2:0] r);
    if (r == 3'd0) return 3'd1;
    if (r > `MAX_ROWS) return `MAX_ROWS;
    return r;
  endfunction : clamp_rows

  function automatic logic [7:0] clamp_addr(input logic [7:0] a);
    if (a < `MIN_ADDR) return `MIN_ADDR;
    if (a > `MAX_ADDR) return `MAX_ADDR;
    return a;
  endfunction : clamp_addr

  function automatic logic [1:0] regs_for(input dtype_t t);
    return (t == DT_U32 || t == DT_S32 || t == DT_FLT) ? 2'd2 : 2'd1;
  endfunction : regs_for

  // View table; indices past forty fold back to line one
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int v = 0; v < 10; v++) begin
        show_ff[v] <= 1'b1;
        rows_ff[v] <= `DEF_ROWS;
        for (int k = 0; k < 4; k++) begin
          idx_ff[v][k] <= `DEF_LINE_IDX;
        end
      end
    end else if (VCFG_WE_IN && VCFG_VIEW_IN < `NUM_VIEWS) begin
      show_ff[VCFG_VIEW_IN] <= VCFG_SHOW_IN;
      rows_ff[VCFG_VIEW_IN] <= clamp_rows(VCFG_ROWS_IN);
      for (int k = 0; k < 4; k++) begin
        idx_ff[VCFG_VIEW_IN][k] <= (VCFG_IDX_IN[6*k +: 6] < `NUM_LINES) ?
          VCFG_IDX_IN[6*k +: 6] : `DEF_LINE_IDX;
      end
    end
  end

  // Line table: address, register, type and decimals
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int l = 0; l < 40; l++) begin
        lslv_ff[l] <= `MIN_ADDR;
        lreg_ff[l] <= 16'h0001;
        ltyp_ff[l] <= DT_U16;
        ldec_ff[l] <= 3'd0;
      end
    end else if (LCFG_WE_IN && LCFG_LINE_IN < `NUM_LINES) begin
      lslv_ff[LCFG_LINE_IN] <= clamp_addr(LCFG_SLAVE_IN);
      lreg_ff[LCFG_LINE_IN] <= LCFG_REG_IN;
      ltyp_ff[LCFG_LINE_IN] <= LCFG_TYPE_IN;
      ldec_ff[LCFG_LINE_IN] <= LCFG_DEC_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Key synchronisers and edge detect
  logic [1:0] up_sync_ff, dn_sync_ff;
  logic       up_prev_ff, dn_prev_ff;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      up_sync_ff <= 2'b00;
      dn_sync_ff <= 2'b00;
      up_prev_ff <= 1'b0;
      dn_prev_ff <= 1'b0;
    end else begin
      up_sync_ff <= {up_sync_ff[0], KEY_UP_IN};
      dn_sync_ff <= {dn_sync_ff[0], KEY_DOWN_IN};
      up_prev_ff <= up_sync_ff[1];
      dn_prev_ff <= dn_sync_ff[1];
    end
  end
  logic up_evt, dn_evt;
  assign up_evt = up_sync_ff[1] & ~up_prev_ff;
  assign dn_evt = dn_sync_ff[1] & ~dn_prev_ff;

  //////////////////////////////////////////////////////////////////////////
  // Dwell timer: a one-second enable and a seconds counter
  logic [31:0] sec_cnt_ff;
  logic [5:0]  dwell_ff;
  logic        sec_tick, dwell_done, step_fwd, step_bwd;
  logic [5:0]  dwell_lim;
  assign sec_tick  = (sec_cnt_ff == 32'(SEC_CYC - 1));
  // Out-of-range settings fall back to the default dwell
  assign dwell_lim = (DWELL_SEC_IN < `DWELL_MIN || DWELL_SEC_IN > `DWELL_MAX)
                     ? `DWELL_DEF : DWELL_SEC_IN;
  assign dwell_done = AUTO_SCROLL_IN && sec_tick &&
                      (dwell_ff + 6'd1 >= dwell_lim);
  assign step_fwd  = up_evt | dwell_done;
  assign step_bwd  = dn_evt & ~up_evt;

  // Any step restarts the dwell so a key press gets a full period
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sec_cnt_ff <= 32'd0;
      dwell_ff   <= 6'd0;
    end else if (step_fwd || step_bwd || !AUTO_SCROLL_IN) begin
      sec_cnt_ff <= 32'd0;
      dwell_ff   <= 6'd0;
    end else if (sec_tick) begin
      sec_cnt_ff <= 32'd0;
      dwell_ff   <= dwell_ff + 6'd1;
    end else begin
      sec_cnt_ff <= sec_cnt_ff + 32'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next shown view in either direction, hidden ones skipped
  function automatic logic [3:0] next_view(input logic [3:0] cur,
                                           input logic fwd);
    logic [3:0] c;
    c = cur;
    for (int n = 0; n < 10; n++) begin
      if (fwd) c = (c == 4'd9) ? 4'd0 : c + 4'd1;
      else     c = (c == 4'd0) ? 4'd9 : c - 4'd1;
      if (show_ff[c]) return c;
    end
    return cur;
  endfunction : next_view

  logic [3:0] view_ff;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      view_ff <= 4'd0;
    end else if (step_fwd) begin
      view_ff <= next_view(view_ff, 1'b1);
    end else if (step_bwd) begin
      view_ff <= next_view(view_ff, 1'b0);
    end else if (!show_ff[view_ff]) begin
      view_ff <= next_view(view_ff, 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Presentation outputs for the current view
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      VIEW_OUT       <= 4'd0;
      ROWS_OUT       <= `DEF_ROWS;
      FONT_SIZE_OUT  <= 2'd3;
      ROW_HEIGHT_OUT <= 8'd192;
      RD_VALUE_OUT   <= 32'd0;
      RD_SLAVE_OUT   <= `MIN_ADDR;
      RD_REG_OUT     <= 16'h0001;
      RD_TYPE_OUT    <= DT_U16;
      RD_DEC_OUT     <= 3'd0;
    end else begin
      VIEW_OUT <= view_ff;
      ROWS_OUT <= rows_ff[view_ff];
      // Fewer rows get taller rows and larger glyphs
      unique case (rows_ff[view_ff])
        3'd1:    begin FONT_SIZE_OUT <= 2'd3; ROW_HEIGHT_OUT <= 8'd192; end
        3'd2:    begin FONT_SIZE_OUT <= 2'd2; ROW_HEIGHT_OUT <= 8'd96;  end
        3'd3:    begin FONT_SIZE_OUT <= 2'd1; ROW_HEIGHT_OUT <= 8'd64;  end
        default: begin FONT_SIZE_OUT <= 2'd0; ROW_HEIGHT_OUT <= 8'd48;  end
      endcase
      // Value, type and decimals by line index, source address and register
      RD_VALUE_OUT <= lval_ff[idx_ff[view_ff][RD_ROW_IN]];
      RD_SLAVE_OUT <= lslv_ff[idx_ff[view_ff][RD_ROW_IN]];
      RD_REG_OUT   <= lreg_ff[idx_ff[view_ff][RD_ROW_IN]];
      RD_TYPE_OUT  <= ltyp_ff[idx_ff[view_ff][RD_ROW_IN]];
      RD_DEC_OUT   <= ldec_ff[idx_ff[view_ff][RD_ROW_IN]];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Backlight PWM from the brightness percentage
  logic [6:0] pwm_ff, bright_lim;
  assign bright_lim = (BRIGHT_PCT_IN < `BRIGHT_MIN ||
                       BRIGHT_PCT_IN > `BRIGHT_MAX)
                      ? `BRIGHT_DEF : BRIGHT_PCT_IN;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pwm_ff        <= 7'd0;
      BACKLIGHT_OUT <= 1'b0;
    end else begin
      pwm_ff        <= (pwm_ff == `PWM_PERIOD - 7'd1) ? 7'd0 : pwm_ff + 7'd1;
      BACKLIGHT_OUT <= (pwm_ff < bright_lim);
    end
  end

  // Own address reaches the slave engine only in slave mode
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SLAVE_ADDR_OUT <= 8'd0;
    end else begin
      SLAVE_ADDR_OUT <= MODE_SLAVE_IN ? clamp_addr(OWN_ADDR_IN)
                                      : 8'd0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Master polling, round robin over rows of shown views
  // Each request is one RTU read frame for the external engine; link
  // speed and framing are fixed there, no port here sets them
  poll_state_t pst_ff;
  logic [3:0]  pview_ff;
  logic [1:0]  prow_ff;
  logic [5:0]  pline_ff;
  logic [31:0] tmo_ff;

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pst_ff         <= PL_IDLE;
      pview_ff       <= 4'd0;
      prow_ff        <= 2'd0;
      pline_ff       <= 6'd0;
      tmo_ff         <= 32'd0;
      POLL_REQ_OUT   <= 1'b0;
      POLL_FUNC_OUT  <= `FUNC_READ;
      POLL_SLAVE_OUT <= `MIN_ADDR;
      POLL_REG_OUT   <= 16'h0001;
      POLL_COUNT_OUT <= 2'd1;
    end else begin
      unique case (pst_ff)
        PL_IDLE: begin
          tmo_ff <= 32'd0;
          if (!MODE_SLAVE_IN && show_ff[pview_ff] &&
              {1'b0, prow_ff} < rows_ff[pview_ff]) begin
            pline_ff       <= idx_ff[pview_ff][prow_ff];
            POLL_FUNC_OUT  <= `FUNC_READ;
            POLL_SLAVE_OUT <= lslv_ff[idx_ff[pview_ff][prow_ff]];
            POLL_REG_OUT   <= lreg_ff[idx_ff[pview_ff][prow_ff]];
            POLL_COUNT_OUT <= regs_for(ltyp_ff[idx_ff[pview_ff][prow_ff]]);
            POLL_REQ_OUT   <= 1'b1;
            pst_ff         <= PL_REQ;
          end else begin
            // Skip rows that are not in use
            prow_ff <= prow_ff + 2'd1;
            if (prow_ff == 2'd3) begin
              pview_ff <= (pview_ff == 4'd9) ? 4'd0 : pview_ff + 4'd1;
            end
          end
        end
        PL_REQ: begin
          if (POLL_ACK_IN) begin
            POLL_REQ_OUT <= 1'b0;
            pst_ff       <= PL_WAIT;
          end
        end
        default: begin
          // A silent slave must not stall the round robin
          tmo_ff <= tmo_ff + 32'd1;
          if (POLL_DONE_IN || tmo_ff == 32'(POLL_TMO - 1)) begin
            pst_ff  <= PL_IDLE;
            prow_ff <= prow_ff + 2'd1;
            if (prow_ff == 2'd3) begin
              pview_ff <= (pview_ff == 4'd9) ? 4'd0 : pview_ff + 4'd1;
            end
          end
        end
      endcase
    end
  end

  // Line values: poll replies in master mode, writes in slave mode
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int l = 0; l < 40; l++) begin
        lval_ff[l] <= 32'd0;
      end
    end else if (!MODE_SLAVE_IN) begin
      if (pst_ff == PL_WAIT && POLL_DONE_IN && POLL_OK_IN) begin
        lval_ff[pline_ff] <= POLL_DATA_IN;
      end
    end else if (SVAL_WE_IN) begin
      for (int l = 0; l < 40; l++) begin
        if (lreg_ff[l] == SVAL_REG_IN) begin
          lval_ff[l] <= SVAL_DATA_IN;
        end
      end
    end
  end
endmodule : view_seq

// ---- rtl/view_consts.svh ----
// Constants for the view sequencer and line poller
// Function
// - At most ten views, one shown
// - Step views by keys or timer
// - Title plus one to four lines
// - Row height and font from line count
// - Per-view show flag, default show
// - Four line indices per view, default one
// - Master mode polls each line itself
// - Slave mode shows last written value
// - Line: slave address, register, data type
// - Fixed or automatic decimal places
// - Value, unit, source and label areas
// - Backlight 10 to 100 percent, default 50
// - Dwell 3 to 60 seconds, default 5
// - Mode select, master by default
// - Own address used only as slave
// - Modbus RTU over RS-485 only
// - Link parameters fixed
// - 19200 baud, 8E1 on every node
// - Hidden views skipped when stepping
// - Only function codes 3 and 16
`ifndef VIEW_CONSTS_SVH
`define VIEW_CONSTS_SVH
`define NUM_VIEWS        4'd10
`define NUM_LINES        6'd40
`define MAX_ROWS         3'd4
`define DEF_ROWS         3'd1
`define DEF_LINE_IDX     6'd0
`define MIN_ADDR         8'd1
`define MAX_ADDR         8'd247
`define BRIGHT_MIN       7'd10
`define BRIGHT_MAX       7'd100
`define BRIGHT_DEF       7'd50
`define DWELL_MIN        6'd3
`define DWELL_MAX        6'd60
`define DWELL_DEF        6'd5
`define CLK_HZ           200000000
`define SEC_CYCLES       (`CLK_HZ)
`define BAUD             19200
`define FUNC_READ        8'h03
`define FUNC_WRITE       8'h10
`define PWM_PERIOD       7'd100
`define POLL_TIMEOUT_MS  100
`define POLL_TIMEOUT_CYC (`POLL_TIMEOUT_MS * (`CLK_HZ / 1000))
`endif

// ---- rtl/view_pkg.sv ----
// Types shared by the view sequencer
package view_pkg;
  typedef enum logic [2:0] {
    DT_U08 = 3'h0, DT_S08 = 3'h1, DT_U16 = 3'h2, DT_S16 = 3'h3,
    DT_U32 = 3'h4, DT_S32 = 3'h5, DT_FLT = 3'h6
  } dtype_t;
  typedef enum logic [2:0] {
    PL_IDLE = 3'b001,
    PL_REQ  = 3'b010,
    PL_WAIT = 3'b100
  } poll_state_t;
endpackage : view_pkg

// ---- bench/view_seq_properties.sv ----
// Port assertions for the view sequencer
`timescale 1ns/10ps
module view_seq_props (
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  input wire logic        MODE_SLAVE_IN,
  input wire logic [7:0]  OWN_ADDR_IN,
  input wire logic        POLL_ACK_IN,
  input wire logic        POLL_REQ_OUT,
  input wire logic [7:0]  POLL_FUNC_OUT,
  input wire logic [15:0] POLL_REG_OUT,
  input wire logic [1:0]  POLL_COUNT_OUT,
  input wire logic [7:0]  SLAVE_ADDR_OUT,
  input wire logic [3:0]  VIEW_OUT,
  input wire logic [2:0]  ROWS_OUT,
  input wire logic [1:0]  FONT_SIZE_OUT,
  input wire logic [7:0]  ROW_HEIGHT_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////
  // Poll handshake: the request waits for the engine, unchanged
  chk_req_hold: assert property (
    POLL_REQ_OUT && !POLL_ACK_IN |=> POLL_REQ_OUT && $stable(POLL_REG_OUT))
    else $error("poll request not held until ack");
  chk_req_release: assert property (
    POLL_REQ_OUT && POLL_ACK_IN |=> !POLL_REQ_OUT)
    else $error("poll request kept after ack");
  chk_read_code: assert property (
    POLL_REQ_OUT |-> POLL_FUNC_OUT == 8'h03)
    else $error("poll uses a function other than read");
  chk_word_count: assert property (
    POLL_REQ_OUT |-> POLL_COUNT_OUT inside {2'h1, 2'h2})
    else $error("poll register count out of range");
  // A slave must never start its own traffic
  chk_slave_quiet: assert property (
    MODE_SLAVE_IN ##1 (MODE_SLAVE_IN && !POLL_REQ_OUT) |=> !POLL_REQ_OUT)
    else $error("poll started in slave mode");
  chk_addr_master: assert property (
    !MODE_SLAVE_IN [*2] |=> SLAVE_ADDR_OUT == 8'h00)
    else $error("own address used in master mode");
  chk_addr_slave: assert property (
    (MODE_SLAVE_IN && OWN_ADDR_IN inside {[8'h01:8'hf7]}) [*2] |=>
    SLAVE_ADDR_OUT == $past(OWN_ADDR_IN))
    else $error("own address not passed on in slave mode");
  ////////////////////////////////////////
  // Layout follows the row count of the current view
  chk_view_range: assert property (
    VIEW_OUT < 4'ha)
    else $error("view index beyond the last view");
  chk_row_font: assert property (
    ROWS_OUT inside {[3'h1:3'h4]} && FONT_SIZE_OUT == 2'(3'h4 - ROWS_OUT))
    else $error("font size does not match row count");
  chk_row_height: assert property (
    11'(ROW_HEIGHT_OUT) * 11'(ROWS_OUT) == 11'h0c0)
    else $error("row height does not match row count");
  cover property (POLL_REQ_OUT && POLL_ACK_IN);
  cover property (MODE_SLAVE_IN && SLAVE_ADDR_OUT != 8'h00);
  cover property ($changed(VIEW_OUT));
endmodule : view_seq_props
bind view_seq view_seq_props u_props (.CLOCK_IN, .RST_B_IN, .MODE_SLAVE_IN,
  .OWN_ADDR_IN, .POLL_ACK_IN, .POLL_REQ_OUT, .POLL_FUNC_OUT, .POLL_REG_OUT,
  .POLL_COUNT_OUT, .SLAVE_ADDR_OUT, .VIEW_OUT, .ROWS_OUT, .FONT_SIZE_OUT,
  .ROW_HEIGHT_OUT);

// ---- bench/poll_engine_model.sv ----
// Behavioural frame engine answering the poll requests
`timescale 1ns/10ps
module poll_engine_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic [7:0]  slave_in,
  input  wire logic [15:0] reg_in,
  output logic             ack_out,
  output logic             done_out,
  output logic             ok_out,
  output logic [31:0]      data_out
);
  logic [7:0]  wait_ff;
  logic        busy_ff;
  logic [31:0] reply_ff;
  ////////////////////////////////////////
  // Take a request after a pause, answer later; between answers the
  // data and status churn so a word picked up early can never match
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_ff  <= 8'h00;
      busy_ff  <= 1'b0;
      reply_ff <= 32'h0;
      ack_out  <= 1'b0;
      done_out <= 1'b0;
      ok_out   <= 1'b0;
      data_out <= 32'h0;
    end else begin
      ack_out  <= 1'b0;
      done_out <= 1'b0;
      ok_out   <= ~ok_out;
      data_out <= ~data_out;
      if (wait_ff != 8'h00) begin
        wait_ff <= wait_ff - 8'h01;
      end else if (busy_ff) begin
        busy_ff  <= 1'b0;
        done_out <= 1'b1;
        ok_out   <= 1'b1;
        data_out <= reply_ff;
        wait_ff  <= slow_in ? 8'h28 : 8'h02;
      end else if (req_in) begin
        busy_ff  <= 1'b1;
        ack_out  <= 1'b1;
        reply_ff <= {reg_in, 8'ha5, slave_in};
        wait_ff  <= slow_in ? 8'h28 : 8'h02;
      end
    end
  end
endmodule : poll_engine_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the view sequencer and its poll partner
`timescale 1ns/10ps
module tb_top;
  import view_pkg::*;
  typedef struct packed {
    logic [2:0] rin;
    logic [2:0] rows;
    logic [1:0] font;
    logic [7:0] hgt;
  } rowcase_t;
  localparam int SEC = 20; // Short second keeps dwell tests brief
  logic        clk = 1'b0, rst_b = 1'b0, up = 1'b0, dn = 1'b0, slow = 1'b0;
  logic        auto_s = 1'b0, slv = 1'b0, vwe = 1'b0, vshow = 1'b1;
  logic        lwe = 1'b0, swe = 1'b0, preq, pack, pdone, pok, blt;
  logic [5:0]  dwell = 6'h03, lline = 6'h00;
  logic [6:0]  bright = 7'h1e;
  logic [7:0]  own = 8'h01, lslave = 8'h01, pfunc, pslave, saddr, height;
  logic [7:0]  rslave;
  logic [3:0]  vview = 4'h0, view;
  logic [2:0]  vrows = 3'h1, ldec = 3'h0, rows, rtype, rdec;
  logic [23:0] vidx = 24'h0;
  logic [15:0] lreg = 16'h0001, sreg = 16'h0000, preg, rreg;
  logic [31:0] sdata = 32'h0, pdata, rval, cnt;
  logic [1:0]  rdrow = 2'h0, pcount, font, pc = 2'h0;
  dtype_t      ltype = DT_U16;
  int          errors = 0, compares = 0, cyc = 0, n;
  rowcase_t    tbl [6] = '{'{3'h1, 3'h1, 2'h3, 8'hc0},
    '{3'h2, 3'h2, 2'h2, 8'h60}, '{3'h3, 3'h3, 2'h1, 8'h40},
    '{3'h4, 3'h4, 2'h0, 8'h30}, '{3'h0, 3'h1, 2'h3, 8'hc0},
    '{3'h7, 3'h4, 2'h0, 8'h30}};
  logic [6:0]  bl_in [3] = '{7'h1e, 7'h05, 7'h64};
  logic [31:0] bl_exp [3] = '{32'h1e, 32'h32, 32'h64};
  ////////////////////////////////////////
  view_seq #(.SEC_CYC(SEC), .POLL_TMO(200)) u_dut (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .KEY_UP_IN(up), .KEY_DOWN_IN(dn),
    .AUTO_SCROLL_IN(auto_s), .DWELL_SEC_IN(dwell), .BRIGHT_PCT_IN(bright),
    .MODE_SLAVE_IN(slv), .OWN_ADDR_IN(own), .VCFG_WE_IN(vwe),
    .VCFG_VIEW_IN(vview), .VCFG_SHOW_IN(vshow), .VCFG_ROWS_IN(vrows),
    .VCFG_IDX_IN(vidx), .LCFG_WE_IN(lwe), .LCFG_LINE_IN(lline),
    .LCFG_SLAVE_IN(lslave), .LCFG_REG_IN(lreg), .LCFG_TYPE_IN(ltype),
    .LCFG_DEC_IN(ldec), .SVAL_WE_IN(swe), .SVAL_REG_IN(sreg),
    .SVAL_DATA_IN(sdata), .POLL_REQ_OUT(preq), .POLL_FUNC_OUT(pfunc),
    .POLL_SLAVE_OUT(pslave), .POLL_REG_OUT(preg), .POLL_COUNT_OUT(pcount),
    .POLL_ACK_IN(pack), .POLL_DONE_IN(pdone), .POLL_OK_IN(pok),
    .POLL_DATA_IN(pdata), .SLAVE_ADDR_OUT(saddr), .VIEW_OUT(view),
    .ROWS_OUT(rows), .FONT_SIZE_OUT(font), .ROW_HEIGHT_OUT(height),
    .RD_ROW_IN(rdrow), .RD_VALUE_OUT(rval), .RD_SLAVE_OUT(rslave),
    .RD_REG_OUT(rreg), .RD_TYPE_OUT(rtype), .RD_DEC_OUT(rdec),
    .BACKLIGHT_OUT(blt));
  poll_engine_model u_eng (
    .clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .req_in(preq),
    .slave_in(pslave), .reg_in(preg), .ack_out(pack), .done_out(pdone),
    .ok_out(pok), .data_out(pdata));
  // Clock, hang guard and capture of the 32-bit poll's word count
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (preq === 1'b1 && pslave === 8'h20) pc <= pcount;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end
  ////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Strobe drops for a cycle so back-to-back writes never collide
  task automatic vcfg(input logic [3:0] v, input logic s,
                      input logic [2:0] r, input logic [23:0] i);
    vview = v;
    vshow = s;
    vrows = r;
    vidx = i;
    vwe = 1'b1;
    tick(1);
    vwe = 1'b0;
    tick(1);
  endtask : vcfg
  task automatic lcfg(input logic [5:0] l, input logic [7:0] a,
                      input logic [15:0] r, input dtype_t t,
                      input logic [2:0] d);
    lline = l;
    lslave = a;
    lreg = r;
    ltype = t;
    ldec = d;
    lwe = 1'b1;
    tick(1);
    lwe = 1'b0;
    tick(1);
  endtask : lcfg
  task automatic wait_val(input logic [31:0] exp);
    n = 0;
    while (rval !== exp && n < 3000) begin
      tick(1);
      n++;
    end
    check(rval, exp);
  endtask : wait_val
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial begin
    tick(6);
    rst_b = 1'b1;
    check(view, 4'h0);
    check(height, 8'hc0);
    check(saddr, 8'h00);
    foreach (tbl[i]) begin
      vcfg(4'h0, 1'b1, tbl[i].rin, 24'h0);
      check(rows, tbl[i].rows);
      check(font, tbl[i].font);
      check(height, tbl[i].hgt);
    end
    lcfg(6'h05, 8'h20, 16'h1234, DT_S32, 3'h6);
    lcfg(6'h06, 8'h00, 16'h0007, DT_U08, 3'h2);
    vcfg(4'h0, 1'b1, 3'h2, {12'h000, 6'h06, 6'h05});
    check(rslave, 8'h20);
    check(rreg, 16'h1234);
    check(rtype, 3'h5);
    check(rdec, 3'h6);
    rdrow = 2'h1;
    tick(2);
    check(rslave, 8'h01);
    check(rdec, 3'h2);
    wait_val(32'h0007a501);
    rdrow = 2'h0;
    wait_val(32'h1234a520);
    check(pc, 2'h2);
    slow = 1'b1;
    lcfg(6'h06, 8'h02, 16'h0008, DT_U16, 3'h0);
    rdrow = 2'h1;
    wait_val(32'h0008a502);
    slow = 1'b0;
    slv = 1'b1;
    own = 8'h30;
    tick(60);
    check(saddr, 8'h30);
    own = 8'h00;
    sreg = 16'h1234;
    sdata = 32'hcafe0001;
    swe = 1'b1;
    tick(1);
    swe = 1'b0;
    rdrow = 2'h0;
    tick(2);
    check(saddr, 8'h01);
    check(rval, 32'hcafe0001);
    slv = 1'b0;
    vcfg(4'h1, 1'b0, 3'h1, 24'h0);
    vcfg(4'h2, 1'b0, 3'h1, 24'h0);
    up = 1'b1;
    tick(6);
    check(view, 4'h3);
    tick(20);
    check(view, 4'h3);
    up = 1'b0;
    tick(3);
    dn = 1'b1;
    tick(6);
    check(view, 4'h0);
    dn = 1'b0;
    auto_s = 1'b1;
    tick(50);
    check(view, 4'h0);
    tick(20);
    check(view, 4'h3);
    dwell = 6'h3d;
    tick(80);
    check(view, 4'h3);
    tick(30);
    check(view, 4'h4);
    auto_s = 1'b0;
    vcfg(4'h4, 1'b0, 3'h1, 24'h0);
    tick(4);
    check(view, 4'h5);
    for (int i = 0; i < 3; i++) begin
      bright = bl_in[i];
      tick(200);
      cnt = 32'h0;
      repeat (100) begin
        tick(1);
        cnt = cnt + {31'h0, blt};
      end
      check(cnt, bl_exp[i]);
    end
    // Mid-run reset: current view 5 and slave address must both clear
    rst_b = 1'b0;
    tick(2);
    check(view, 4'h0);
    check(saddr, 8'h00);
    check(height, 8'hc0);
    rst_b = 1'b1;
    tick(2);
    check(view, 4'h0);
    check(rows, 3'h1);
    results();
  end
endmodule : tb_top
